// ---- slu_pkg.sv ----
// constants and types shared by the scalar logical unit
// What this block does
// - opcode 044 writes AND of first and second source
// - 044 with j zero yields zero; k zero yields sign bit of first
// - opcode 045 writes first source AND complement of second
// - 045 with j equal k or j zero clears; k zero clears sign
// - opcode 046 writes exclusive OR of the two sources
// - 046 equal nonzero designators clear; j zero passes second; k zero toggles sign
// - opcode 047 writes bitwise equivalence of the two sources
// - 047 equal nonzero gives ones; j zero complements second; k zero spares sign
// - 047 with both designators zero gives sign clear, rest set
// - opcode 050 merges first source into old destination under mask
// - 050 j zero clears masked bits; k zero swaps sign; both clears sign
// - opcode 051 writes OR of the two sources
// - 051 special designators pass source, set sign, or give sign mask
// - opcodes 044 through 051 all execute in this logical unit
package slu_pkg;
    localparam int DATA_W = 64;
    localparam int DESIG_W = 3;
    localparam int OPC_W = 9;
    localparam logic [OPC_W-1:0] OPC_AND = 9'h024;   // octal 044
    localparam logic [OPC_W-1:0] OPC_ANDN = 9'h025;  // octal 045
    localparam logic [OPC_W-1:0] OPC_XOR = 9'h026;   // octal 046
    localparam logic [OPC_W-1:0] OPC_EQV = 9'h027;   // octal 047
    localparam logic [OPC_W-1:0] OPC_MRG = 9'h028;   // octal 050
    localparam logic [OPC_W-1:0] OPC_OR = 9'h029;    // octal 051
    localparam logic [DATA_W-1:0] SIGN_MASK = 64'h8000_0000_0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 64'h0;
    localparam logic [DESIG_W-1:0] DESIG_ZERO = 3'h0;
    typedef enum logic [5:0] {
        SLU_AND  = 6'h01,
        SLU_ANDN = 6'h02,
        SLU_XOR  = 6'h04,
        SLU_EQV  = 6'h08,
        SLU_MRG  = 6'h10,
        SLU_OR   = 6'h20
    } slu_func_t;
endpackage : slu_pkg

// ---- slu_operand_sel.sv ----
// operand selection for the two source designators
module slu_operand_sel (
    input  wire logic [slu_pkg::DESIG_W-1:0] desigJ,
    input  wire logic [slu_pkg::DESIG_W-1:0] desigK,
    input  wire logic [slu_pkg::DATA_W-1:0]  firstSourceReg,
    input  wire logic [slu_pkg::DATA_W-1:0]  secondSourceReg,
    output logic      [slu_pkg::DATA_W-1:0]  opJ,
    output logic      [slu_pkg::DATA_W-1:0]  opK
);
    // register zero is never read here: the designator names a constant
    always_comb begin
        opJ = (desigJ == slu_pkg::DESIG_ZERO) ? slu_pkg::ZERO_WORD : firstSourceReg;
        opK = (desigK == slu_pkg::DESIG_ZERO) ? slu_pkg::SIGN_MASK : secondSourceReg;
    end
endmodule : slu_operand_sel

// ---- slu_opcode_dec.sv ----
// opcode decode for the logical unit
module slu_opcode_dec (
    input  wire logic [slu_pkg::OPC_W-1:0] opcode,
    output logic                           accept,
    output slu_pkg::slu_func_t             func
);
    // every opcode 044..051 is claimed, nothing else
    always_comb begin
        accept = 1'b1;
        func   = slu_pkg::SLU_AND;
        unique case (opcode)
            slu_pkg::OPC_AND:  func = slu_pkg::SLU_AND;
            slu_pkg::OPC_ANDN: func = slu_pkg::SLU_ANDN;
            slu_pkg::OPC_XOR:  func = slu_pkg::SLU_XOR;
            slu_pkg::OPC_EQV:  func = slu_pkg::SLU_EQV;
            slu_pkg::OPC_MRG:  func = slu_pkg::SLU_MRG;
            slu_pkg::OPC_OR:   func = slu_pkg::SLU_OR;
            default:           accept = 1'b0;
        endcase
    end
endmodule : slu_opcode_dec

// ---- slu_scalar_logical_unit.sv ----
// scalar logical unit: one-cycle pipelined bitwise operations 044..051
module slu_scalar_logical_unit (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          issueValid,
    input  wire logic [slu_pkg::OPC_W-1:0]     opcode,
    input  wire logic [slu_pkg::DESIG_W-1:0]   desigI,
    input  wire logic [slu_pkg::DESIG_W-1:0]   desigJ,
    input  wire logic [slu_pkg::DESIG_W-1:0]   desigK,
    input  wire logic [slu_pkg::DATA_W-1:0]    firstSourceReg,
    input  wire logic [slu_pkg::DATA_W-1:0]    secondSourceReg,
    input  wire logic [slu_pkg::DATA_W-1:0]    destOldReg,
    output logic                               issueAccept,
    output logic                               resultValid,
    output logic      [slu_pkg::DESIG_W-1:0]   resultDesig,
    output logic      [slu_pkg::DATA_W-1:0]    resultData
);
    logic [slu_pkg::DATA_W-1:0]  opJ;
    logic [slu_pkg::DATA_W-1:0]  opK;
    logic                        decAccept;
    slu_pkg::slu_func_t          func;
    logic [slu_pkg::DATA_W-1:0]  result_nxt;
    logic                        resultValid_r;
    logic [slu_pkg::DESIG_W-1:0] resultDesig_r;
    logic [slu_pkg::DATA_W-1:0]  resultData_r;
    logic                        jZero;
    logic                        kZero;
    logic                        sameJK;

    slu_operand_sel u_sel (
        .desigJ          (desigJ),
        .desigK          (desigK),
        .firstSourceReg  (firstSourceReg),
        .secondSourceReg (secondSourceReg),
        .opJ             (opJ),
        .opK             (opK)
    );

    slu_opcode_dec u_dec (
        .opcode (opcode),
        .accept (decAccept),
        .func   (func)
    );

    assign issueAccept = issueValid & decAccept;

    // the special designator cases fall out of the constant operands alone;
    // no extra muxing, so all corner forms share one datapath
    always_comb begin
        result_nxt = slu_pkg::ZERO_WORD;
        unique case (func)
            slu_pkg::SLU_AND:  result_nxt = opJ & opK;
            slu_pkg::SLU_ANDN: result_nxt = opJ & ~opK;
            slu_pkg::SLU_XOR:  result_nxt = opJ ^ opK;
            slu_pkg::SLU_EQV:  result_nxt = ~(opJ ^ opK);
            slu_pkg::SLU_MRG:  result_nxt = (opJ & opK) | (destOldReg & ~opK);
            slu_pkg::SLU_OR:   result_nxt = opJ | opK;
        endcase
    end

    // result handshake: one-cycle valid pulse per accepted issue
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resultValid_r <= 1'b0;
        end else begin
            resultValid_r <= issueAccept;
        end
    end

    // result word and destination designator hold until next accepted issue
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resultData_r  <= slu_pkg::ZERO_WORD;
            resultDesig_r <= slu_pkg::DESIG_ZERO;
        end else if (issueAccept) begin
            resultData_r  <= result_nxt;
            resultDesig_r <= desigI;
        end
    end

    assign resultValid = resultValid_r;
    assign resultDesig = resultDesig_r;
    assign resultData  = resultData_r;

    // sign-bit helpers for the checks below; the sign is the top bit of the word
    function automatic logic [slu_pkg::DATA_W-1:0] clear_sign(
        input logic [slu_pkg::DATA_W-1:0] w
    );
        return w & ~slu_pkg::SIGN_MASK;
    endfunction : clear_sign

    function automatic logic [slu_pkg::DATA_W-1:0] set_sign(
        input logic [slu_pkg::DATA_W-1:0] w
    );
        return w | slu_pkg::SIGN_MASK;
    endfunction : set_sign

    function automatic logic [slu_pkg::DATA_W-1:0] flip_sign(
        input logic [slu_pkg::DATA_W-1:0] w
    );
        return w ^ slu_pkg::SIGN_MASK;
    endfunction : flip_sign

    // range test kept apart from the decoder so the checks do not copy it
    function automatic logic is_logical(
        input logic [slu_pkg::OPC_W-1:0] op
    );
        return (op >= slu_pkg::OPC_AND) && (op <= slu_pkg::OPC_OR);
    endfunction : is_logical

    // designator tests read only by the checks
    assign jZero  = (desigJ == slu_pkg::DESIG_ZERO);
    assign kZero  = (desigK == slu_pkg::DESIG_ZERO);
    assign sameJK = (desigJ == desigK);

    // checks compare against the raw register words, not the muxed operands,
    // so a broken operand select shows up as a wrong result

    // a zero designator must replace the register read by a constant; a nonzero one passes the register word
    a_opj_zero: assert property (@(posedge clk_sys) disable iff (reset)
        jZero
        |-> opJ == slu_pkg::ZERO_WORD)
        else $error("zero j operand not zero");
    a_opk_sign: assert property (@(posedge clk_sys) disable iff (reset)
        kZero
        |-> opK == slu_pkg::SIGN_MASK)
        else $error("zero k operand not sign mask");
    a_opj_pass: assert property (@(posedge clk_sys) disable iff (reset)
        !jZero
        |-> opJ == firstSourceReg)
        else $error("nonzero j operand not passed");
    a_opk_pass: assert property (@(posedge clk_sys) disable iff (reset)
        !kZero
        |-> opK == secondSourceReg)
        else $error("nonzero k operand not passed");

    // logical product and its special forms
    a_and_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_AND && !jZero && !kZero
        |=> resultData == ($past(firstSourceReg) & $past(secondSourceReg)))
        else $error("and result wrong");
    a_and_same: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_AND && sameJK && !jZero
        |=> resultData == $past(firstSourceReg))
        else $error("and same designators not passed");
    a_and_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_AND && jZero
        |=> resultData == slu_pkg::ZERO_WORD)
        else $error("and with zero j not zero");
    a_and_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_AND && !jZero && kZero
        |=> resultData == ($past(firstSourceReg) & slu_pkg::SIGN_MASK))
        else $error("and sign extract wrong");

    // product with complement; equal designators cancel to zero
    a_andn_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_ANDN && !jZero && !kZero
        |=> resultData == ($past(firstSourceReg) & ~$past(secondSourceReg)))
        else $error("andn result wrong");
    a_andn_same: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_ANDN && sameJK
        |=> resultData == slu_pkg::ZERO_WORD)
        else $error("andn same designators not zero");
    a_andn_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_ANDN && jZero
        |=> resultData == slu_pkg::ZERO_WORD)
        else $error("andn zero j not zero");
    a_andn_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_ANDN && !jZero && kZero
        |=> resultData == clear_sign($past(firstSourceReg)))
        else $error("andn sign clear wrong");

    // logical difference; the sign mask operand toggles only the sign
    a_xor_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_XOR && !jZero && !kZero
        |=> resultData == ($past(firstSourceReg) ^ $past(secondSourceReg)))
        else $error("xor result wrong");
    a_xor_same: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_XOR && sameJK && !jZero
        |=> resultData == slu_pkg::ZERO_WORD)
        else $error("xor same designators not zero");
    a_xor_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_XOR && jZero && !kZero
        |=> resultData == $past(secondSourceReg))
        else $error("xor pass second wrong");
    a_xor_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_XOR && !jZero && kZero
        |=> resultData == flip_sign($past(firstSourceReg)))
        else $error("xor sign toggle wrong");
    a_xor_both0: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_XOR && jZero && kZero
        |=> resultData == slu_pkg::SIGN_MASK)
        else $error("xor both zero wrong");

    // equivalence is the complement of the difference, corner forms included
    a_eqv_value: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_EQV && !jZero && !kZero
        |=> resultData == ~($past(firstSourceReg) ^ $past(secondSourceReg)))
        else $error("eqv result wrong");
    a_eqv_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_EQV && sameJK && !jZero
        |=> &resultData)
        else $error("eqv same designators not ones");
    a_eqv_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_EQV && jZero && !kZero
        |=> resultData == ~$past(secondSourceReg))
        else $error("eqv zero j not complement");
    a_eqv_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_EQV && !jZero && kZero
        |=> resultData == ~flip_sign($past(firstSourceReg)))
        else $error("eqv zero k spared wrong bits");
    a_eqv_both0: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_EQV && jZero && kZero
        |=> resultData == ~slu_pkg::SIGN_MASK)
        else $error("eqv both zero wrong");

    // merge reads the old destination word; a stale forward would show here
    // first, since no other opcode depends on it
    a_mrg_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && !jZero && !kZero
        |=> resultData == (($past(firstSourceReg) & $past(secondSourceReg))
            | ($past(destOldReg) & ~$past(secondSourceReg))))
        else $error("merge result wrong");
    a_mrg_same: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && sameJK && !jZero
        |=> resultData == ($past(firstSourceReg) | $past(destOldReg)))
        else $error("merge same designators wrong");
    a_mrg_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && jZero && !kZero
        |=> resultData == ($past(destOldReg) & ~$past(secondSourceReg)))
        else $error("merge zero j did not clear");
    a_mrg_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && kZero
        |=> clear_sign(resultData) == clear_sign($past(destOldReg)))
        else $error("merge touched non sign bits");
    a_mrg_sign: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && !jZero && kZero
        |=> resultData[slu_pkg::DATA_W-1] == $past(firstSourceReg[slu_pkg::DATA_W-1]))
        else $error("merge sign not replaced");
    a_mrg_both0: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_MRG && jZero && kZero
        |=> resultData == clear_sign($past(destOldReg)))
        else $error("merge both zero wrong");

    // logical sum; a zero k forces the sign bit on
    a_or_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_OR && !jZero && !kZero
        |=> resultData == ($past(firstSourceReg) | $past(secondSourceReg)))
        else $error("or result wrong");
    a_or_same: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_OR && sameJK && !jZero
        |=> resultData == $past(firstSourceReg))
        else $error("or same designators not passed");
    a_or_jzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_OR && jZero && !kZero
        |=> resultData == $past(secondSourceReg))
        else $error("or zero j not passed");
    a_or_kzero: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_OR && !jZero && kZero
        |=> resultData == set_sign($past(firstSourceReg)))
        else $error("or sign set wrong");
    a_or_both0: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept && opcode == slu_pkg::OPC_OR && jZero && kZero
        |=> resultData == slu_pkg::SIGN_MASK)
        else $error("or both zero wrong");

    // issue handshake: claim exactly the six opcodes, answer one cycle later
    // and hold the result word and designator, valid low, when nothing is taken
    a_accept_range: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && is_logical(opcode)
        |-> issueAccept ##1 resultValid)
        else $error("logical opcode not taken");
    a_refuse_other: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && !is_logical(opcode)
        |-> !issueAccept)
        else $error("foreign opcode taken");
    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        !issueAccept
        |=> !resultValid)
        else $error("result valid without issue");
    a_result_held: assert property (@(posedge clk_sys) disable iff (reset)
        !issueAccept
        |=> $stable(resultData) && $stable(resultDesig))
        else $error("result changed without issue");
    a_desig_follow: assert property (@(posedge clk_sys) disable iff (reset)
        issueAccept
        |=> resultDesig == $past(desigI))
        else $error("result designator wrong");
    a_func_onehot: assert property (@(posedge clk_sys) disable iff (reset)
        decAccept
        |-> $onehot(func))
        else $error("function select not one hot");

    // reset leaves every registered result output at its idle value one edge later
    a_reset_clear: assert property (@(posedge clk_sys)
        reset
        |=> !resultValid && resultData == slu_pkg::ZERO_WORD
            && resultDesig == slu_pkg::DESIG_ZERO)
        else $error("outputs not cleared by reset");
endmodule : slu_scalar_logical_unit

// ---- slu_regfile_model.sv ----
// scalar register file model on the far side of the logical unit
module slu_regfile_model (
    input  wire logic        clk_sys,
    input  wire logic        loadEn,
    input  wire logic [2:0]  loadIdx,
    input  wire logic [63:0] loadData,
    input  wire logic [2:0]  desigI,
    input  wire logic [2:0]  desigJ,
    input  wire logic [2:0]  desigK,
    input  wire logic        resultValid,
    input  wire logic [2:0]  resultDesig,
    input  wire logic [63:0] resultData,
    output logic      [63:0] firstSourceReg,
    output logic      [63:0] secondSourceReg,
    output logic      [63:0] destOldReg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] mem [8];
    // bench preload wins; otherwise results retire on the edge that samples the pulse
    always_ff @(posedge clk_sys) begin
        if (loadEn) begin
            mem[loadIdx] <= loadData;
        end else if (resultValid) begin
            mem[resultDesig] <= resultData;
        end
    end
    // write-through forwarding so back-to-back dependent issues see fresh data
    assign firstSourceReg  = (resultValid && resultDesig == desigJ) ? resultData : mem[desigJ];
    assign secondSourceReg = (resultValid && resultDesig == desigK) ? resultData : mem[desigK];
    assign destOldReg      = (resultValid && resultDesig == desigI) ? resultData : mem[desigI];
endmodule : slu_regfile_model

// ---- tb_scalar_logical_unit.sv ----
// self-checking bench for the scalar logical unit
module tb_scalar_logical_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, reset = 1'b1, issueValid = 1'b0, loadEn = 1'b0;
    logic [8:0]  opcode = 9'h000;
    logic [2:0]  desigI = 3'h0, desigJ = 3'h0, desigK = 3'h0, loadIdx = 3'h0;
    logic [63:0] loadData = 64'h0, fsr, ssr, dor, resultData, lastE;
    logic        issueAccept, resultValid;
    logic [2:0]  resultDesig;
    logic [63:0] mirror [8];
    int          n_mismatch = 0, cmp_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    slu_scalar_logical_unit dut (.clk_sys(clk_sys), .reset(reset), .issueValid(issueValid),
        .opcode(opcode), .desigI(desigI), .desigJ(desigJ), .desigK(desigK),
        .firstSourceReg(fsr), .secondSourceReg(ssr), .destOldReg(dor),
        .issueAccept(issueAccept), .resultValid(resultValid), .resultDesig(resultDesig),
        .resultData(resultData));
    slu_regfile_model regs (.clk_sys(clk_sys), .loadEn(loadEn), .loadIdx(loadIdx),
        .loadData(loadData), .desigI(desigI), .desigJ(desigJ), .desigK(desigK),
        .resultValid(resultValid), .resultDesig(resultDesig), .resultData(resultData),
        .firstSourceReg(fsr), .secondSourceReg(ssr), .destOldReg(dor));
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // expected word from the operand substitutions, never from the design
    function automatic logic [63:0] expv(logic [8:0] op, logic [2:0] i, j, k);
        logic [63:0] a, b;
        a = (j == 3'h0) ? slu_pkg::ZERO_WORD : mirror[j];
        b = (k == 3'h0) ? slu_pkg::SIGN_MASK : mirror[k];
        case (op)
            slu_pkg::OPC_AND:  return a & b;
            slu_pkg::OPC_ANDN: return a & ~b;
            slu_pkg::OPC_XOR:  return a ^ b;
            slu_pkg::OPC_EQV:  return ~(a ^ b);
            slu_pkg::OPC_MRG:  return (a & b) | (mirror[i] & ~b);
            default:           return a | b;
        endcase
    endfunction : expv
    // entered at a falling edge, returns at the falling edge after the result
    task automatic issue(logic [8:0] op, logic [2:0] i, j, k);
        lastE = expv(op, i, j, k);
        {opcode, desigI, desigJ, desigK} = {op, i, j, k};
        issueValid = 1'b1;
        #1 chk("accept", 64'(issueAccept), 64'h1);
        @(negedge clk_sys);
        chk("valid", 64'(resultValid), 64'h1);
        chk("desig", 64'(resultDesig), 64'(i));
        chk("data", resultData, lastE);
        mirror[i] = lastE;
    endtask : issue
    // every opcode against plain, zero and equal designators, back to back
    task automatic t_all_ops();
        logic [2:0] jt[5] = '{3'h3, 3'h0, 3'h3, 3'h4, 3'h0};
        logic [2:0] kt[5] = '{3'h5, 3'h5, 3'h0, 3'h4, 3'h0};
        for (int o = 0; o < 6; o++) begin
            for (int n = 0; n < 5; n++) begin
                issue(9'(slu_pkg::OPC_AND + o), 3'h6, jt[n], kt[n]);
            end
        end
        issue(slu_pkg::OPC_EQV, 3'h1, 3'h0, 3'h0);
        chk("eqv00", resultData, 64'h7fff_ffff_ffff_ffff);
        issue(slu_pkg::OPC_OR, 3'h2, 3'h0, 3'h0);
        chk("or00", resultData, 64'h8000_0000_0000_0000);
        issueValid = 1'b0;
        @(negedge clk_sys);
        chk("pulse", 64'(resultValid), 64'h0);
    endtask : t_all_ops
    // neighbouring opcodes belong to other units: no result, outputs held
    task automatic t_refused();
        logic [8:0] bad[3] = '{9'h023, 9'h02a, 9'h124};
        for (int n = 0; n < 3; n++) begin
            issueValid = 1'b1;
            opcode = bad[n];
            #1 chk("refuse", 64'(issueAccept), 64'h0);
            @(negedge clk_sys);
            chk("noresult", 64'(resultValid), 64'h0);
            chk("held", resultData, lastE);
            chk("heldesig", 64'(resultDesig), 64'h2);
        end
        issueValid = 1'b0;
    endtask : t_refused
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        chk("rstvalid", 64'(resultValid), 64'h0);
        chk("rstdata", resultData, 64'h0);
        chk("rstdesig", 64'(resultDesig), 64'h0);
        // register zero holds a nonzero pattern so its contents must be ignored
        for (int n = 0; n < 8; n++) begin
            loadEn = 1'b1;
            loadIdx = 3'(n);
            loadData = {8{8'h5a}} ^ (64'h0123_4567_89ab_cdef * 64'(n + 3));
            mirror[n] = loadData;
            @(negedge clk_sys);
        end
        loadEn = 1'b0;
        t_all_ops();
        t_refused();
        final_report();
    end
endmodule : tb_scalar_logical_unit
